// file: logic/ccp_standard_pwm.sv
// standard-mode pwm generator with apb register access
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module ccp_standard_pwm (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // power state
  input wire logic sleep,
  // pulse output pin
  output pwm_pkg::pin_t pwm_pin
);
  import pwm_pkg::*;

  logic [3:0] mode_reg;
  logic [7:0] duty_high_buffer_reg;
  logic [1:0] duty_low_bits_reg;
  duty_t duty_active_reg;
  logic [7:0] period_limit_reg;
  logic [1:0] prescale_sel_reg;
  logic timebase_run_reg;
  logic [3:0] postscale_sel_reg;
  logic [7:0] timebase_count_reg;
  logic [5:0] div_reg;
  logic match_flag_reg;
  logic pin_direction_reg;
  logic pin_level_reg;
  logic pin_oe_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  logic pwm_mode;
  logic running;
  logic tick;
  logic rollover;
  logic [5:0] div_last;
  logic [1:0] sub_bits;
  duty_t timebase;
  duty_t duty_buffered;
  logic wr_en;
  logic mapped;
  logic [31:0] rd_value;
  logic step;
  logic match_next;

  // mode decode
  always_comb
  begin
    case (mode_t'(mode_reg))
      MODE_PWM0, MODE_PWM1, MODE_PWM2, MODE_PWM3: pwm_mode = 1'b1;
      default: pwm_mode = 1'b0;
    endcase
  end

  // prescale decode; postscale is stored but never used here
  always_comb
  begin
    case (prescale_t'(prescale_sel_reg))
      PS_DIV1: div_last = DIV_LAST_PS1;
      PS_DIV4: div_last = DIV_LAST_PS4;
      default: div_last = DIV_LAST_PS16;
    endcase
  end

  // low timebase bits: oscillator phase at 1:1, prescaler bits otherwise
  always_comb
  begin
    case (prescale_t'(prescale_sel_reg))
      PS_DIV1: sub_bits = div_reg[1:0];
      PS_DIV4: sub_bits = div_reg[3:2];
      default: sub_bits = div_reg[5:4];
    endcase
  end

  // timebase advance: its low bits move on at this edge
  always_comb
  begin
    case (prescale_t'(prescale_sel_reg))
      PS_DIV1: step = running;
      PS_DIV4: step = running & (div_reg[1:0] == DIV_LAST_PS1[1:0]);
      default: step = running & (div_reg[3:0] == DIV_LAST_PS4[3:0]);
    endcase
  end

  // timebase reaches the active duty at the next edge, so the pin falls on time
  assign match_next = step & (({1'b0, timebase} + 11'h001) == {1'b0, duty_active_reg});

  // sleep stops all counting
  assign running = timebase_run_reg & ~sleep;
  // one increment every 4 x prescale oscillator clocks
  assign tick = running & (div_reg == div_last);
  assign rollover = tick & (timebase_count_reg == period_limit_reg);
  assign timebase = '{high: timebase_count_reg, low: sub_bits};
  assign duty_buffered = '{high: duty_high_buffer_reg, low: duty_low_bits_reg};

  // apb decode
  assign wr_en = psel & penable & pready_reg & pwrite;
  always_comb
  begin
    mapped = 1'b1;
    rd_value = 32'h0000_0000;
    case (paddr)
      ADDR_CCP_CONTROL:
        rd_value[7:0] = {2'b00, duty_low_bits_reg, mode_reg};
      ADDR_DUTY_HIGH_BUFFER:
        rd_value[7:0] = duty_high_buffer_reg;
      ADDR_DUTY_ACTIVE_HIGH:
        rd_value[7:0] = duty_active_reg.high;
      ADDR_PERIOD_LIMIT:
        rd_value[7:0] = period_limit_reg;
      ADDR_TIMEBASE_CONTROL:
        rd_value[7:0] = {1'b0, postscale_sel_reg, timebase_run_reg, prescale_sel_reg};
      ADDR_TIMEBASE_COUNT:
        rd_value[7:0] = timebase_count_reg;
      ADDR_FLAGS:
        rd_value[MATCH_FLAG_BIT] = match_flag_reg;
      ADDR_PIN_CONTROL:
        rd_value[PIN_DIR_BIT] = pin_direction_reg;
      default:
        mapped = 1'b0;
    endcase
  end

  // apb answer, one access cycle, registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= psel & ~penable;
      prdata_reg <= (psel & ~penable & ~pwrite) ? rd_value : 32'h0000_0000;
      pslverr_reg <= psel & ~penable & ~mapped;
    end
  end

  // control registers, writable any time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_reg <= CCP_CONTROL_RST[MODE_LSB +: 4];
      duty_low_bits_reg <= CCP_CONTROL_RST[DUTY_LOW_LSB +: 2];
      duty_high_buffer_reg <= DUTY_HIGH_RST;
      period_limit_reg <= PERIOD_LIMIT_RST;
      prescale_sel_reg <= TIMEBASE_CONTROL_RST[PRESCALE_LSB +: 2];
      timebase_run_reg <= TIMEBASE_CONTROL_RST[RUN_BIT];
      postscale_sel_reg <= TIMEBASE_CONTROL_RST[POSTSCALE_LSB +: 4];
      pin_direction_reg <= PIN_DIR_RST;
    end
    else if (wr_en && mapped)
    begin
      case (paddr)
        ADDR_CCP_CONTROL:
        begin
          mode_reg <= pwdata[MODE_LSB +: 4];
          duty_low_bits_reg <= pwdata[DUTY_LOW_LSB +: 2];
        end
        ADDR_DUTY_HIGH_BUFFER: duty_high_buffer_reg <= pwdata[7:0];
        ADDR_PERIOD_LIMIT: period_limit_reg <= pwdata[7:0];
        ADDR_TIMEBASE_CONTROL:
        begin
          prescale_sel_reg <= pwdata[PRESCALE_LSB +: 2];
          timebase_run_reg <= pwdata[RUN_BIT];
          postscale_sel_reg <= pwdata[POSTSCALE_LSB +: 4];
        end
        ADDR_PIN_CONTROL: pin_direction_reg <= pwdata[PIN_DIR_BIT];
        default: pin_direction_reg <= pin_direction_reg;
      endcase
    end
  end

  // oscillator phase and prescaler divider
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_reg <= 6'h00;
    else if (wr_en && paddr == ADDR_TIMEBASE_COUNT)
      div_reg <= 6'h00;
    else if (tick)
      div_reg <= 6'h00;
    else if (running)
      div_reg <= div_reg + 6'h01;
  end

  // period timer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timebase_count_reg <= TIMEBASE_COUNT_RST;
    else if (wr_en && paddr == ADDR_TIMEBASE_COUNT)
      timebase_count_reg <= pwdata[7:0];
    else if (rollover)
      timebase_count_reg <= 8'h00;
    else if (tick)
      timebase_count_reg <= timebase_count_reg + 8'h01;
  end

  // match flag: set at rollover wins over a software clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      match_flag_reg <= 1'b0;
    else if (rollover)
      match_flag_reg <= 1'b1;
    else if (wr_en && paddr == ADDR_FLAGS)
      match_flag_reg <= pwdata[MATCH_FLAG_BIT];
  end

  // active duty: latched at rollover, read-only in pwm mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      duty_active_reg <= '0;
    else if (mode_reg == MODE_OFF)
      duty_active_reg <= '0;
    else if (rollover && pwm_mode)
      duty_active_reg <= duty_buffered;
    else if (!pwm_mode && wr_en && paddr == ADDR_DUTY_ACTIVE_HIGH)
      duty_active_reg.high <= pwdata[7:0];
  end

  // pin level flip-flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_level_reg <= 1'b0;
    else if (!pwm_mode)
      pin_level_reg <= 1'b0;
    else if (rollover)
      pin_level_reg <= (duty_buffered != '0);
    else if (match_next)
      pin_level_reg <= 1'b0; // duty past period never matches
  end

  // output driver: only in pwm mode with pin set as output
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_oe_reg <= 1'b0;
    else
      pin_oe_reg <= pwm_mode & ~pin_direction_reg;
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pwm_pin = '{level: pin_level_reg, oe: pin_oe_reg};

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // apb answer
  a_pready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after a setup cycle");

  a_pready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");

  a_unmapped_error: assert property (psel && !penable && !mapped |=> pslverr)
    else $error("unmapped access not flagged");

  a_prdata_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside a read answer");

  // timer and divider
  a_period_wrap_clear: assert property (rollover |=> timebase_count_reg == 8'h00)
    else $error("timebase did not clear at rollover");

  a_timer_step_up: assert property (
    tick && !rollover && !(wr_en && paddr == ADDR_TIMEBASE_COUNT)
      |=> timebase_count_reg == $past(timebase_count_reg) + 8'h01)
    else $error("timer did not advance on its increment");

  a_tick_divide_ratio: assert property (tick |-> div_reg == div_last && running)
    else $error("timer increment off the divide ratio");

  a_ps1_tick_spacing: assert property (
    tick && prescale_sel_reg == PS_DIV1 && !sleep && timebase_run_reg && !wr_en
      |=> !tick [*3])
    else $error("1:1 increments closer than four clocks");

  a_tick_on_step: assert property (tick |-> step)
    else $error("timer increment without a timebase step");

  // duty buffering
  a_duty_latch_copy: assert property (
    rollover && pwm_mode && mode_reg != MODE_OFF
      |=> duty_active_reg == $past(duty_buffered))
    else $error("duty not latched at rollover");

  a_buffer_no_glitch: assert property (
    !rollover && mode_reg != MODE_OFF && !(wr_en && paddr == ADDR_DUTY_ACTIVE_HIGH)
      |=> $stable(duty_active_reg))
    else $error("active duty moved inside a period");

  a_active_write_ignored: assert property (
    pwm_mode && wr_en && paddr == ADDR_DUTY_ACTIVE_HIGH && !rollover
      |=> $stable(duty_active_reg))
    else $error("active duty took a write in pwm mode");

  // pin level
  a_pin_set_start: assert property (
    rollover && pwm_mode
      |=> pin_level_reg == ($past(duty_buffered) != '0))
    else $error("pin level wrong at period start");

  a_zero_duty_low: assert property (
    rollover && pwm_mode && duty_buffered == '0 |=> !pin_level_reg)
    else $error("pin set with zero duty");

  a_pin_match_clear: assert property (
    pwm_mode && !rollover && match_next |=> !pin_level_reg)
    else $error("pin not cleared at duty match");

  a_wide_duty_hold: assert property (
    pwm_mode && !rollover && !wr_en && div_reg <= div_last
      && timebase_count_reg <= period_limit_reg
      && duty_active_reg > {period_limit_reg, 2'b11}
      |=> $stable(pin_level_reg))
    else $error("pin cleared with duty beyond the period");

  // sleep
  a_sleep_state_hold: assert property (
    sleep && !wr_en |=> $stable(timebase_count_reg) && $stable(pin_level_reg))
    else $error("state moved during sleep");

  a_sleep_div_hold: assert property (
    sleep && !wr_en |=> $stable(div_reg) && $stable(match_flag_reg))
    else $error("divider or flag moved during sleep");

  // flag
  a_match_flag_set: assert property (rollover |=> match_flag_reg)
    else $error("match flag not set at rollover");

  a_flag_hold: assert property (
    !rollover && !(wr_en && paddr == ADDR_FLAGS) |=> $stable(match_flag_reg))
    else $error("match flag moved without cause");

  // unit off and pin driver
  a_off_release_pin: assert property (
    mode_reg == MODE_OFF |=> !pwm_pin.oe && !pwm_pin.level)
    else $error("pin still driven with unit off");

  a_off_duty_clear: assert property (
    mode_reg == MODE_OFF |=> duty_active_reg == '0)
    else $error("active duty kept with unit off");

  a_oe_on_output: assert property (
    pwm_mode && !pin_direction_reg |=> pwm_pin.oe)
    else $error("driver off with pin set as output");

  a_oe_off_input: assert property (pin_direction_reg |=> !pwm_pin.oe)
    else $error("driver on with pin set as input");

  c_rollover_high: cover property (rollover && pwm_mode && duty_buffered != '0);
  c_match_clear: cover property (pin_level_reg ##1 !pin_level_reg);
  c_sleep_hold: cover property (running ##1 sleep [*3]);
  c_flag_clear: cover property (match_flag_reg ##1 !match_flag_reg);
  c_duty_zero: cover property (rollover && pwm_mode && duty_buffered == '0);
endmodule : ccp_standard_pwm

// file: logic/pwm_pkg.sv
// package: register map, fields, reset values and types of the standard pwm unit
//Contract
//- period is (period_limit+1) x 4 oscillator clocks x prescale factor
//- increment after timebase_count equals period_limit clears it and starts a period
//- pin goes high at period start unless duty value is zero
//- at rollover buffered duty copies into duty_active_high and the 2-bit latch
//- duty is 10 bits: duty_high_buffer upper eight, ccp_control bits 5:4 lower two
//- duty writes accepted anytime, take effect only at next rollover
//- in pwm mode duty_active_high reads back but ignores writes
//- duty is double buffered through duty_active_high and hidden latch, no glitches
//- 10-bit timebase is timebase_count plus phase bits or prescaler bits
//- timebase equal to active duty drives pin low for rest of period
//- high time equals duty x oscillator period x prescale factor
//- duty beyond period length leaves the pin unchanged, no clearing edge
//- postscaler has no effect on pwm period
//- prescale select offers division by 1, 4 and 16
//- resolution is log2(4 x (period_limit+1)), 10 bits at limit 255
//- in sleep counter and all state hold, pin keeps level
//- reset makes pin an input and loads all reset values
//- period rollover sets timebase_match_flag
//- mode field zero turns unit off, resets it, releases the pin
package pwm_pkg;
  localparam logic [7:0] ADDR_CCP_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_DUTY_HIGH_BUFFER = 8'h04;
  localparam logic [7:0] ADDR_DUTY_ACTIVE_HIGH = 8'h08;
  localparam logic [7:0] ADDR_PERIOD_LIMIT = 8'h0c;
  localparam logic [7:0] ADDR_TIMEBASE_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_TIMEBASE_COUNT = 8'h14;
  localparam logic [7:0] ADDR_FLAGS = 8'h18;
  localparam logic [7:0] ADDR_PIN_CONTROL = 8'h1c;
  // ccp_control fields
  localparam int MODE_LSB = 0;
  localparam int DUTY_LOW_LSB = 4;
  // timebase_control fields
  localparam int PRESCALE_LSB = 0;
  localparam int RUN_BIT = 2;
  localparam int POSTSCALE_LSB = 3;
  // flag register and pin control bit positions
  localparam int MATCH_FLAG_BIT = 1;
  localparam int PIN_DIR_BIT = 0;
  // reset values
  localparam logic [7:0] CCP_CONTROL_RST = 8'h00;
  localparam logic [7:0] DUTY_HIGH_RST = 8'h00;
  localparam logic [7:0] PERIOD_LIMIT_RST = 8'hff;
  localparam logic [7:0] TIMEBASE_CONTROL_RST = 8'h00;
  localparam logic [7:0] TIMEBASE_COUNT_RST = 8'h00;
  localparam logic PIN_DIR_RST = 1'b1;
  // oscillator clocks per timer increment at 1:1
  localparam int OSC_PER_INCR = 4;
  localparam logic [5:0] DIV_LAST_PS1 = 6'h03;
  localparam logic [5:0] DIV_LAST_PS4 = 6'h0f;
  localparam logic [5:0] DIV_LAST_PS16 = 6'h3f;

  typedef enum logic [3:0] {
    MODE_OFF = 4'b0000,
    MODE_PWM0 = 4'b1100,
    MODE_PWM1 = 4'b1101,
    MODE_PWM2 = 4'b1110,
    MODE_PWM3 = 4'b1111
  } mode_t;

  typedef enum logic [1:0] {
    PS_DIV1 = 2'b00,
    PS_DIV4 = 2'b01,
    PS_DIV16 = 2'b10,
    PS_DIV16B = 2'b11
  } prescale_t;

  typedef struct packed {
    logic [7:0] high;
    logic [1:0] low;
  } duty_t;

  typedef struct packed {
    logic level;
    logic oe;
  } pin_t;
endpackage : pwm_pkg

// file: verification/load_model.sv
// load model: pulled-down load on the pwm pin that measures pulse and period
`timescale 1ns/1ps
module load_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin and measurements
  input wire pwm_pkg::pin_t pin,
  output logic meas,
  output int hi,
  output int per
);
  import pwm_pkg::*;
  logic line;
  logic line_d;
  logic rise;
  int cnt;
  int hcnt;
  // a released pin falls to the pull-down level
  assign line = pin.oe ? pin.level : 1'b0;
  assign rise = line & ~line_d;
  // count cycles between rising edges and high cycles in between
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      {line_d, meas, cnt, hcnt, hi, per} <= '0;
    end
    else
    begin
      line_d <= line;
      meas <= rise;
      cnt <= rise ? 1 : cnt + 1;
      hcnt <= rise ? 1 : hcnt + int'(line);
      if (rise)
      begin
        hi <= hcnt;
        per <= cnt;
      end
    end
endmodule : load_model

// file: verification/testbench.sv
// testbench: register access and pwm waveform checks against the load model
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("wrong value at %0t: got %0h want %0h", $time, g, e); \
    end \
  end
module testbench;
  import pwm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep, meas, lvl;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [32:0] e;
  logic [32:0] rq[$];
  int hq[$];
  int pq[$];
  pin_t pwm_pin;
  int hi, per, eh, ep, lim, duty, f, n, bad_count, cmp_count;

  ccp_standard_pwm i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep(sleep), .pwm_pin(pwm_pin));
  load_model i_load (.pclk(pclk), .presetn(presetn), .pin(pwm_pin), .meas(meas),
    .hi(hi), .per(per));

  always #12.5 pclk = ~pclk;

  task automatic conclude;
    if (bad_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input int d);
    apb(1'b1, a, 32'(d));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [32:0] x);
    rq.push_back(x);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // compare results against the oldest noted expectation
  always @(posedge pclk)
  begin
    if (psel && penable && pready && !pwrite && rq.size() > 0)
    begin
      e = rq.pop_front();
      `CHK({pslverr, prdata}, e)
    end
    if (meas && hq.size() > 0)
    begin
      eh = hq.pop_front();
      ep = pq.pop_front();
      `CHK(hi, eh)
      `CHK(per, ep)
    end
  end

  initial
  begin
    #(25 * 40000);
    bad_count++;
    conclude();
  end

  initial
  begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, sleep} = '0;
    bad_count = 0;
    cmp_count = 0;
    n = $urandom(45115);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_PERIOD_LIMIT, {25'h0, PERIOD_LIMIT_RST});
    rd(ADDR_PIN_CONTROL, 33'h1);
    rd(ADDR_CCP_CONTROL, 33'h0);
    rd(8'h3c, {1'b1, 32'h0});
    for (int ps = 0; ps < 3; ps++)
    begin
      f = 1 << (2 * ps);
      lim = 1 + $urandom % 6;
      duty = 1 + $urandom % (4 * lim + 3);
      wr(ADDR_PIN_CONTROL, 1);
      wr(ADDR_TIMEBASE_CONTROL, 0);
      wr(ADDR_TIMEBASE_COUNT, 0);
      wr(ADDR_PERIOD_LIMIT, lim);
      wr(ADDR_CCP_CONTROL, int'(MODE_PWM0) + ps);
      wr(ADDR_DUTY_HIGH_BUFFER, duty >> 2);
      wr(ADDR_CCP_CONTROL, ((duty & 3) << 4) + int'(MODE_PWM0) + ps);
      wr(ADDR_FLAGS, 0);
      wr(ADDR_TIMEBASE_CONTROL, ($urandom % 16) * 8 + 4 + ps);
      n = 0;
      do
      begin
        apb(1'b0, ADDR_FLAGS, 32'h0);
        n++;
      end
      while (r[MATCH_FLAG_BIT] !== 1'b1 && n < 400);
      `CHK(r[MATCH_FLAG_BIT], 1'b1)
      wr(ADDR_PIN_CONTROL, 0);
      repeat (2) do @(posedge pclk); while (meas !== 1'b1);
      @(posedge pclk);
      hq.push_back(duty * f);
      pq.push_back((lim + 1) * 4 * f);
      while (hq.size() > 0) @(posedge pclk);
      wr(ADDR_DUTY_ACTIVE_HIGH, 8'h55);
      rd(ADDR_DUTY_ACTIVE_HIGH, 33'(duty >> 2));
    end
    sleep <= 1'b1;
    apb(1'b0, ADDR_TIMEBASE_COUNT, 32'h0);
    lvl = pwm_pin.level;
    repeat (100) @(posedge pclk);
    rd(ADDR_TIMEBASE_COUNT, {1'b0, r});
    `CHK(pwm_pin.level, lvl)
    sleep <= 1'b0;
    wr(ADDR_CCP_CONTROL, 0);
    rd(ADDR_DUTY_ACTIVE_HIGH, 33'h0);
    `CHK(pwm_pin, 2'b00)
    conclude();
  end
endmodule : testbench
